// file: logic/logic_stage.sv
// one logic stage: eight lanes, each inverting, selecting and and/or-combining eight inputs
// assumes inputs and config are stable within a cycle; purely combinational
`timescale 1ns/100ps
module logic_stage (
    input  wire output_logic_pkg::lane_t       in_bits,
    input  wire output_logic_pkg::lane_array_t invert_words,
    input  wire output_logic_pkg::lane_array_t select_words,
    input  wire output_logic_pkg::lane_t       and_mode,
    output      output_logic_pkg::lane_t       out_bits
);
    import output_logic_pkg::*;

    // an empty selection yields 0 in both modes, so an unused lane never reads as active
    function automatic logic combine_lane(input lane_t bits, input lane_t inv, input lane_t sel, input logic use_and);
        lane_t eff;
        eff = bits ^ inv;
        if (sel == 8'h00) begin
            combine_lane = 1'b0;
        end else if (use_and) begin
            combine_lane = ((eff & sel) == sel);
        end else begin
            combine_lane = |(eff & sel);
        end
    endfunction

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            out_bits[i] = combine_lane(in_bits, invert_words[i], select_words[i], and_mode[i]);
        end
    end
endmodule // logic_stage

// file: logic/output_logic_defines.svh
// offsets, reset values and widths of the two-stage output logic
// assumes a 32-bit apb slave with byte addresses and one aligned word per register
`ifndef OUTPUT_LOGIC_DEFINES_SVH
`define OUTPUT_LOGIC_DEFINES_SVH

`define LANES             8
`define ADDR_W            12
`define OFS_COND_INVERT   12'h000
`define OFS_COND_SELECT   12'h020
`define OFS_FLAG_AND_OR   12'h040
`define OFS_OUT_AND_OR    12'h044
`define OFS_FINAL_INVERT  12'h048
`define OFS_TERM_ALLOC    12'h04c
`define OFS_FLAG_INVERT   12'h050
`define OFS_FLAG_SELECT   12'h070
`define OFS_PRE_STATE     12'h090
`define OFS_TERM_STATE    12'h094
`define ARRAY_SPAN        12'h020
`define RST_WORD          8'h00
`define RST_TERM_ALLOC    8'he4

`endif

// file: logic/output_logic_pkg.sv
// types shared by the two-stage output logic
// assumes the defines header is compiled alongside
package output_logic_pkg;
    typedef logic [7:0]      lane_t;
    typedef lane_t [7:0]     lane_array_t;
    typedef logic [1:0]      alloc_code_t;
endpackage

// file: logic/terminal_router.sv
// maps four allocation fields onto the four physical terminal signals
// assumes the field code indexes the low four pre-allocation outputs
`timescale 1ns/100ps
module terminal_router (
    input  wire output_logic_pkg::lane_t alloc_word,
    input  wire output_logic_pkg::lane_t pre_outputs,
    output      logic [3:0]              terminals
);
    import output_logic_pkg::*;

    function automatic logic pick(input lane_t outs, input alloc_code_t code);
        pick = outs[code];
    endfunction

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            terminals[k] = pick(pre_outputs, alloc_code_t'(alloc_word[2*k +: 2]));
        end
    end
endmodule // terminal_router

// file: logic/two_stage_output_logic.sv
// top of the two-stage digital output logic with its apb register file
// assumes switching conditions arrive synchronous to core_clk, one bit per assigned condition
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "output_logic_defines.svh"
module two_stage_output_logic (
    input  wire  logic                            core_clk,
    input  wire  logic                            rst_n,
    input  wire  logic                            psel,
    input  wire  logic                            penable,
    input  wire  logic                            pwrite,
    input  wire  logic [11:0]                     paddr,
    input  wire  logic [31:0]                     pwdata,
    input  wire  logic [3:0]                      pstrb,
    output       logic [31:0]                     prdata,
    output       logic                            pready,
    output       logic                            pslverr,
    input  wire  output_logic_pkg::lane_t         switching_cond,
    output       logic                            transistor_out_a,
    output       logic                            transistor_out_b,
    output       logic                            relay_out_a,
    output       logic                            relay_out_b,
    output       logic                            internal_out_a,
    output       logic                            internal_out_b,
    output       logic                            internal_out_c,
    output       logic                            internal_out_d
);
    import output_logic_pkg::*;

    typedef struct packed {
        lane_array_t cond_invert;
        lane_array_t cond_select;
        lane_array_t flag_invert;
        lane_array_t flag_select;
        lane_t       flag_and_or;
        lane_t       out_and_or;
        lane_t       final_invert;
        lane_t       term_alloc;
        lane_t       pre_state;
        lane_t       term_state;
        logic [3:0]  term_out;
        logic [31:0] rdata;
    } state_s;

    state_s     st_reg;
    state_s     st_next;
    lane_t      flags;
    lane_t      out_raw;
    lane_t      pre_outputs;
    logic [3:0] terminals;
    logic       setup_phase;
    logic       access_phase;
    logic       wr_take;
    logic       mapped;
    logic [31:0] rd_word;

    logic_stage u_stage_one (
        .in_bits      (switching_cond),
        .invert_words (st_reg.cond_invert),
        .select_words (st_reg.cond_select),
        .and_mode     (st_reg.flag_and_or),
        .out_bits     (flags)
    );

    logic_stage u_stage_two (
        .in_bits      (flags),
        .invert_words (st_reg.flag_invert),
        .select_words (st_reg.flag_select),
        .and_mode     (st_reg.out_and_or),
        .out_bits     (out_raw)
    );

    assign pre_outputs = out_raw ^ st_reg.final_invert;

    terminal_router u_router (
        .alloc_word  (st_reg.term_alloc),
        .pre_outputs (pre_outputs),
        .terminals   (terminals)
    );

    function automatic logic in_array(input logic [11:0] a, input logic [11:0] base);
        in_array = (a >= base) && (a < base + `ARRAY_SPAN) && (a[1:0] == 2'b00);
    endfunction

    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    // zero wait states: read data was latched at the setup edge, so access can finish at once
    assign pready       = access_phase;
    assign pslverr      = access_phase && !mapped;
    assign prdata       = st_reg.rdata;
    assign wr_take      = access_phase && pwrite && mapped && pstrb[0];

    always_comb begin
        mapped  = 1'b1;
        rd_word = 32'h0000_0000;
        if (in_array(paddr, `OFS_COND_INVERT)) begin
            rd_word[7:0] = st_reg.cond_invert[paddr[4:2]];
        end else if (in_array(paddr, `OFS_COND_SELECT)) begin
            rd_word[7:0] = st_reg.cond_select[paddr[4:2]];
        end else if (in_array(paddr, `OFS_FLAG_INVERT)) begin
            rd_word[7:0] = st_reg.flag_invert[3'(paddr[4:2] - 3'h4)];
        end else if (in_array(paddr, `OFS_FLAG_SELECT)) begin
            rd_word[7:0] = st_reg.flag_select[3'(paddr[4:2] - 3'h4)];
        end else begin
            unique case (paddr)
                `OFS_FLAG_AND_OR:  rd_word[7:0] = st_reg.flag_and_or;
                `OFS_OUT_AND_OR:   rd_word[7:0] = st_reg.out_and_or;
                `OFS_FINAL_INVERT: rd_word[7:0] = st_reg.final_invert;
                `OFS_TERM_ALLOC:   rd_word[7:0] = st_reg.term_alloc;
                `OFS_PRE_STATE:    rd_word[7:0] = st_reg.pre_state;
                `OFS_TERM_STATE:   rd_word[7:0] = st_reg.term_state;
                default:           mapped = 1'b0;
            endcase
        end
    end

    always_comb begin
        st_next = st_reg;
        if (setup_phase && !pwrite) begin
            st_next.rdata = rd_word;
        end
        // status words are read-only; writes to them are silently dropped
        if (wr_take) begin
            if (in_array(paddr, `OFS_COND_INVERT)) begin
                st_next.cond_invert[paddr[4:2]] = pwdata[7:0];
            end else if (in_array(paddr, `OFS_COND_SELECT)) begin
                st_next.cond_select[paddr[4:2]] = pwdata[7:0];
            end else if (in_array(paddr, `OFS_FLAG_INVERT)) begin
                st_next.flag_invert[3'(paddr[4:2] - 3'h4)] = pwdata[7:0];
            end else if (in_array(paddr, `OFS_FLAG_SELECT)) begin
                st_next.flag_select[3'(paddr[4:2] - 3'h4)] = pwdata[7:0];
            end else begin
                unique case (paddr)
                    `OFS_FLAG_AND_OR:  st_next.flag_and_or  = pwdata[7:0];
                    `OFS_OUT_AND_OR:   st_next.out_and_or   = pwdata[7:0];
                    `OFS_FINAL_INVERT: st_next.final_invert = pwdata[7:0];
                    `OFS_TERM_ALLOC:   st_next.term_alloc   = pwdata[7:0];
                    default:           st_next.rdata        = st_reg.rdata;
                endcase
            end
        end
        st_next.pre_state  = pre_outputs;
        st_next.term_out   = terminals;
        st_next.term_state = {pre_outputs[7:4], terminals};
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg              <= '0;
            st_reg.term_alloc   <= `RST_TERM_ALLOC;
            st_reg.final_invert <= `RST_WORD;
        end else begin
            st_reg <= st_next;
        end
    end

    assign transistor_out_a = st_reg.term_out[0];
    assign transistor_out_b = st_reg.term_out[1];
    assign relay_out_a      = st_reg.term_out[2];
    assign relay_out_b      = st_reg.term_out[3];
    assign internal_out_a   = st_reg.pre_state[4];
    assign internal_out_b   = st_reg.pre_state[5];
    assign internal_out_c   = st_reg.pre_state[6];
    assign internal_out_d   = st_reg.pre_state[7];

    a_flag_or_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!st_reg.flag_and_or[0] && |(st_reg.cond_select[0] & (switching_cond ^ st_reg.cond_invert[0]))) |-> flags[0])
        else $error("flag 0 not set in or mode");
    a_flag_none_sel: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_reg.cond_select[3] == 8'h00) |-> !flags[3])
        else $error("flag 3 set with empty selection");
    a_flag_or_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!st_reg.flag_and_or[1] && !(|(st_reg.cond_select[1] & (switching_cond ^ st_reg.cond_invert[1])))) |-> !flags[1])
        else $error("flag 1 set with no true condition");
    a_flag_and_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_reg.flag_and_or[2] && ((st_reg.cond_select[2] & (switching_cond ^ st_reg.cond_invert[2]))
            != st_reg.cond_select[2])) |-> !flags[2])
        else $error("flag 2 set though an and term is false");
    a_out_or_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!st_reg.out_and_or[0] && |(st_reg.flag_select[0] & (flags ^ st_reg.flag_invert[0]))) |-> out_raw[0])
        else $error("output 0 not active in or mode");
    a_out_and_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_reg.out_and_or[5] && st_reg.flag_select[5] != 8'h00
            && ((st_reg.flag_select[5] & (flags ^ st_reg.flag_invert[5])) == st_reg.flag_select[5])) |-> out_raw[5])
        else $error("output 5 inactive though all flags set");
    a_final_invert: assert property (@(posedge core_clk) disable iff (!rst_n)
        ##1 st_reg.pre_state == $past(out_raw ^ st_reg.final_invert))
        else $error("pre-allocation status does not match inverted outputs");
    a_status_layout: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_reg.term_state == {st_reg.pre_state[7:4], st_reg.term_out})
        else $error("terminal status word layout wrong");
    a_alloc_route: assert property (@(posedge core_clk) disable iff (!rst_n)
        ##1 relay_out_b == $past(pre_outputs[st_reg.term_alloc[7:6]]))
        else $error("relay b not routed by its allocation field");
    a_cfg_next_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
        (access_phase && pwrite && pstrb[0] && paddr == `OFS_FINAL_INVERT) |=> st_reg.final_invert == $past(pwdata[7:0]))
        else $error("final inversion write not applied next cycle");

    // stage one: inversion and both combinations; the bench drives lane 1 into both modes, lanes 0 and 3 into or mode only
    a_cond_invert: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!st_reg.flag_and_or[0] && st_reg.cond_select[0] == 8'h05 && st_reg.cond_invert[0] == 8'h04)
            |-> flags[0] == (switching_cond[0] || !switching_cond[2]))
        else $error("flag 0 does not follow its inverted conditions");

    a_flag_inv_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!st_reg.flag_and_or[3] && |(st_reg.cond_select[3] & (switching_cond ^ st_reg.cond_invert[3]))) |-> flags[3])
        else $error("flag 3 not set in or mode");

    a_flag_and_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_reg.flag_and_or[1] && st_reg.cond_select[1] != 8'h00
            && ((st_reg.cond_select[1] & (switching_cond ^ st_reg.cond_invert[1])) == st_reg.cond_select[1]))
            |-> flags[1])
        else $error("flag 1 clear though all and terms are true");

    // stage two and final inversion, checked on the pins too so a wiring slip is caught
    a_out_or_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!st_reg.out_and_or[0] && !(|(st_reg.flag_select[0] & (flags ^ st_reg.flag_invert[0])))) |-> !out_raw[0])
        else $error("output 0 active with no flag set");

    a_out_none_sel: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_reg.flag_select[6] == 8'h00) |-> !out_raw[6])
        else $error("output 6 active with empty selection");

    a_out_and_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_reg.out_and_or[4] && ((st_reg.flag_select[4] & (flags ^ st_reg.flag_invert[4])) != st_reg.flag_select[4]))
            |-> !out_raw[4])
        else $error("output 4 active though an and term is false");

    a_out_invert: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!st_reg.out_and_or[0] && st_reg.flag_select[0] == 8'h01 && st_reg.flag_invert[0] == 8'h01)
            |-> out_raw[0] == !flags[0])
        else $error("output 0 does not follow its inverted flag");

    a_internal_invert: assert property (@(posedge core_clk) disable iff (!rst_n)
        ##1 {internal_out_d, internal_out_c, internal_out_b, internal_out_a}
            == $past(out_raw[7:4] ^ st_reg.final_invert[7:4]))
        else $error("internal outputs not inverted by the final word");

    a_invert_next: assert property (@(posedge core_clk) disable iff (!rst_n)
        (access_phase && pwrite && pstrb[0] && paddr == `OFS_FINAL_INVERT)
            |=> ##1 st_reg.pre_state == ($past(out_raw) ^ $past(pwdata[7:0], 2)))
        else $error("new final inversion not seen on the status one cycle later");

    // allocation and the two status words
    a_alloc_trans_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ##1 transistor_out_a == $past(pre_outputs[st_reg.term_alloc[1:0]]))
        else $error("transistor a not routed by its allocation field");

    a_alloc_trans_b: assert property (@(posedge core_clk) disable iff (!rst_n)
        ##1 transistor_out_b == $past(pre_outputs[st_reg.term_alloc[3:2]]))
        else $error("transistor b not routed by its allocation field");

    a_alloc_relay_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ##1 relay_out_a == $past(pre_outputs[st_reg.term_alloc[5:4]]))
        else $error("relay a not routed by its allocation field");

    a_term_pins: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_reg.term_state[3:0] == {relay_out_b, relay_out_a, transistor_out_b, transistor_out_a})
        else $error("terminal status bits differ from the terminal pins");

    a_internal_pins: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_reg.term_state[7:4] == {internal_out_d, internal_out_c, internal_out_b, internal_out_a})
        else $error("terminal status high bits differ from the internal outputs");

    a_read_pre: assert property (@(posedge core_clk) disable iff (!rst_n)
        (setup_phase && !pwrite && paddr == `OFS_PRE_STATE) |=> prdata == {24'h00_0000, $past(st_reg.pre_state)})
        else $error("pre-allocation status read back wrong");

    a_read_term: assert property (@(posedge core_clk) disable iff (!rst_n)
        (setup_phase && !pwrite && paddr == `OFS_TERM_STATE) |=> prdata == {24'h00_0000, $past(st_reg.term_state)})
        else $error("terminal status read back wrong");

    // register writes land on the edge that completes the access; status words ignore them
    a_status_ro: assert property (@(posedge core_clk) disable iff (!rst_n)
        (access_phase && pwrite && (paddr == `OFS_PRE_STATE || paddr == `OFS_TERM_STATE))
            |=> $stable(st_reg.term_alloc) && $stable(st_reg.final_invert))
        else $error("write to a status word changed the configuration");

    a_invert_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (access_phase && pwrite && pstrb[0] && paddr == `OFS_COND_INVERT)
            |=> st_reg.cond_invert[0] == $past(pwdata[7:0]))
        else $error("condition inversion word 0 not written");

    a_select_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (access_phase && pwrite && pstrb[0] && paddr == `OFS_COND_SELECT + 12'h01c)
            |=> st_reg.cond_select[7] == $past(pwdata[7:0]))
        else $error("condition selection word 7 not written");

    a_flag_and_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (access_phase && pwrite && pstrb[0] && paddr == `OFS_FLAG_AND_OR)
            |=> st_reg.flag_and_or == $past(pwdata[7:0]))
        else $error("stage one combination word not written");

    a_finv_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (access_phase && pwrite && pstrb[0] && paddr == `OFS_FLAG_INVERT)
            |=> st_reg.flag_invert[0] == $past(pwdata[7:0]))
        else $error("flag inversion word 0 not written");

    a_fsel_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (access_phase && pwrite && pstrb[0] && paddr == `OFS_FLAG_SELECT + 12'h01c)
            |=> st_reg.flag_select[7] == $past(pwdata[7:0]))
        else $error("flag selection word 7 not written");

    a_out_and_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (access_phase && pwrite && pstrb[0] && paddr == `OFS_OUT_AND_OR)
            |=> st_reg.out_and_or == $past(pwdata[7:0]))
        else $error("stage two combination word not written");

    a_alloc_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (access_phase && pwrite && pstrb[0] && paddr == `OFS_TERM_ALLOC)
            |=> st_reg.term_alloc == $past(pwdata[7:0]))
        else $error("allocation word not written");

    // bus answers: zero wait states, errors for unaligned addresses and for those beyond the register map
    a_unmapped_err: assert property (@(posedge core_clk) disable iff (!rst_n)
        (access_phase && paddr >= 12'h098) |-> pslverr)
        else $error("no error for an address beyond the map");

    a_ready_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        !psel |-> (!pready && !pslverr))
        else $error("ready or error raised while not selected");

    a_read_high_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        (access_phase && !pwrite) |-> prdata[31:8] == 24'h00_0000)
        else $error("unused read data bits not zero");
endmodule // two_stage_output_logic

// file: tb/terminal_load.sv
// far-side model of the four output terminals: passes the driven levels to the bench
// assumes push-pull levels, no pull resistors, all sampled in the core_clk domain
`timescale 1ns/100ps
module terminal_load (
    input  wire logic [3:0] drive,
    output      logic [3:0] level
);
    // terminals are plain loads: they show exactly what the block drives
    assign level = drive;
endmodule // terminal_load

// file: tb/two_stage_output_logic_test.sv
// self-checking bench for the two-stage output logic, driven over apb
// assumes 40 ns core_clk, zero-wait apb slave, registered outputs one edge after input
`timescale 1ns/100ps
`include "output_logic_defines.svh"
module two_stage_output_logic_test;
    import output_logic_pkg::*;
    logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    lane_t       switching_cond, fand, oand, fout, alloc, cur;
    lane_array_t cinv, csel, finv, fsel;
    logic        ta, tb, ra, rb, ia, ib, ic, id;
    logic [3:0]  level;
    int          fails, checks_done;

    two_stage_output_logic dut_u (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .switching_cond(switching_cond), .transistor_out_a(ta), .transistor_out_b(tb),
        .relay_out_a(ra), .relay_out_b(rb), .internal_out_a(ia), .internal_out_b(ib),
        .internal_out_c(ic), .internal_out_d(id));
    terminal_load load_u (.drive({rb, ra, tb, ta}), .level(level));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic complete_run();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
            fails++;
        end
    endtask

    // holds the request until pready is seen or 20 edges pass; the trailing edge keeps back-to-back strobes apart
    task automatic apb(input logic wr, input logic [11:0] a, input lane_t d, output logic [31:0] rd,
                       output logic er);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check("pready", {31'h0, pready}, 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    // reset values of every register word, mirrored by the bench model
    task automatic model_reset();
        cinv = '0;
        csel = '0;
        finv = '0;
        fsel = '0;
        fand = 8'h00;
        oand = 8'h00;
        fout = 8'h00;
        alloc = `RST_TERM_ALLOC;
    endtask

    task automatic put(input logic [11:0] a, input lane_t d);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, rd, er);
        check("put_err", {31'h0, er}, 32'h0);
        if (a < `OFS_COND_SELECT) cinv[a[4:2]] = d;
        else if (a < `OFS_FLAG_AND_OR) csel[a[4:2]] = d;
        else if (a == `OFS_FLAG_AND_OR) fand = d;
        else if (a == `OFS_OUT_AND_OR) oand = d;
        else if (a == `OFS_FINAL_INVERT) fout = d;
        else if (a == `OFS_TERM_ALLOC) alloc = d;
        else if (a < `OFS_FLAG_SELECT) finv[3'((a - `OFS_FLAG_INVERT) >> 2)] = d;
        else fsel[3'((a - `OFS_FLAG_SELECT) >> 2)] = d;
    endtask

    // empty selection yields 0 in either mode
    function automatic lane_t stage(lane_t x, lane_array_t inv, lane_array_t sel, lane_t am);
        lane_t r;
        lane_t v;
        for (int i = 0; i < 8; i++) begin
            v = (x ^ inv[i]) & sel[i];
            r[i] = (sel[i] == 8'h00) ? 1'b0 : (am[i] ? (v == sel[i]) : (v != 8'h00));
        end
        return r;
    endfunction

    function automatic logic [15:0] model(lane_t c);
        lane_t      p;
        logic [3:0] t;
        p = stage(stage(c, cinv, csel, fand), finv, fsel, oand) ^ fout;
        for (int k = 0; k < 4; k++) t[k] = p[alloc[2*k+:2]];
        return {p[7:4], t, p};
    endfunction

    task automatic look_ports();
        logic [15:0] e;
        e = model(cur);
        check("terminals", {24'h0, id, ic, ib, ia, level}, {24'h0, e[15:8]});
    endtask

    task automatic look(input lane_t c);
        logic [15:0] e;
        logic [31:0] rd;
        logic        er;
        switching_cond <= c;
        cur = c;
        repeat (3) @(posedge core_clk);
        e = model(c);
        look_ports();
        apb(1'b0, `OFS_PRE_STATE, 8'h00, rd, er);
        check("pre_state", rd, {24'h0, e[7:0]});
        apb(1'b0, `OFS_TERM_STATE, 8'h00, rd, er);
        check("term_state", rd, {24'h0, e[15:8]});
    endtask

    task automatic s_reset();
        logic [31:0] rd;
        logic        er;
        apb(1'b0, `OFS_TERM_ALLOC, 8'h00, rd, er);
        check("alloc_reset", rd, 32'h0000_00e4);
        look(8'hff);
    endtask

    task automatic s_stage_one();
        lane_t pats[9] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h3c, 8'h7f, 8'hff, 8'h80, 8'he0};
        for (int j = 0; j < 8; j++) put(`OFS_FLAG_SELECT + 12'(4*j), 8'h01 << j);
        put(`OFS_COND_SELECT, 8'h05);
        put(`OFS_COND_INVERT, 8'h04);
        put(`OFS_COND_SELECT + 12'h004, 8'hff);
        put(`OFS_COND_SELECT + 12'h008, 8'h3c);
        put(`OFS_COND_SELECT + 12'h00c, 8'h81);
        put(`OFS_COND_INVERT + 12'h00c, 8'h80);
        put(`OFS_FLAG_AND_OR, 8'h06);
        foreach (pats[i]) look(pats[i]);
        for (int j = 0; j < 8; j++) put(`OFS_COND_SELECT + 12'(4*j), 8'h01 << j);
        put(`OFS_COND_INVERT, 8'h00);
        put(`OFS_COND_INVERT + 12'h00c, 8'h00);
        put(`OFS_FLAG_AND_OR, 8'h00);
        put(`OFS_FLAG_INVERT, 8'h01);
        put(`OFS_FLAG_SELECT + 12'h010, 8'h0f);
        put(`OFS_FLAG_INVERT + 12'h010, 8'h03);
        put(`OFS_FLAG_SELECT + 12'h014, 8'hf0);
        put(`OFS_FLAG_INVERT + 12'h014, 8'h10);
        put(`OFS_FLAG_SELECT + 12'h018, 8'h00);
        put(`OFS_OUT_AND_OR, 8'h30);
        put(`OFS_FINAL_INVERT, 8'h41);
        foreach (pats[i]) look(pats[i]);
    endtask

    // two condition patterns keep every pair of field codes apart
    task automatic s_alloc();
        lane_t words[5] = '{8'h00, 8'h55, 8'haa, 8'hff, 8'h1b};
        logic [31:0] rd;
        logic        er;
        foreach (words[i]) begin
            put(`OFS_TERM_ALLOC, words[i]);
            @(posedge core_clk);
            look_ports();
            look(8'h05);
            look(8'h03);
        end
        apb(1'b0, 12'h0a0, 8'h00, rd, er);
        check("unmapped_err", {31'h0, er}, 32'h1);
        check("unmapped_data", rd, 32'h0);
        apb(1'b1, `OFS_TERM_STATE, 8'hff, rd, er);
        check("status_write_err", {31'h0, er}, 32'h0);
        apb(1'b1, `OFS_PRE_STATE, 8'hff, rd, er);
        check("status_write_err", {31'h0, er}, 32'h0);
        look(8'h0c);
    endtask

    // a second reset in mid-run must bring every word and output back to its reset value
    task automatic s_mid_reset();
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        check("reset_outputs", {24'h0, id, ic, ib, ia, level}, 32'h0);
        rst_n <= 1'b1;
        model_reset();
        @(posedge core_clk);
        s_reset();
    endtask

    initial begin
        #(40 * 20000);
        fails++;
        complete_run();
    end

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        switching_cond = 8'h00;
        fails = 0;
        checks_done = 0;
        model_reset();
        cur = 8'h00;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        s_reset();
        s_stage_one();
        s_alloc();
        s_mid_reset();
        complete_run();
    end
endmodule // two_stage_output_logic_test
